// File: core/ccac_top.sv
// ccac_top: charger configuration and measurement control register bank.
// assumes a synchronous byte register port from the serial interface logic,
// and analog status levels (junction hot, thermistor cool zone, conversion
// done) that are asynchronous and therefore synchronised here.
`timescale 1ns/1ns
module ccac_top
  import ccac_pkg::*;
#(
  parameter int RAMP0_CYC = CCAC_RAMP0_CYC,
  parameter int RAMP1_CYC = CCAC_RAMP1_CYC,
  parameter int RAMP2_CYC = CCAC_RAMP2_CYC,
  parameter int RAMP3_CYC = CCAC_RAMP3_CYC,
  parameter int RATE0_CYC = CCAC_RATE0_CYC,
  parameter int RATE1_CYC = CCAC_RATE1_CYC,
  parameter int RATE2_CYC = CCAC_RATE2_CYC,
  parameter int RATE3_CYC = CCAC_RATE3_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_ack,
  input wire logic [7:0] fast_charge_current_code,
  input wire logic junction_over_setpoint,
  input wire logic thermistor_cool_zone,
  input wire logic conversion_done,
  output logic thermal_regulation_flag,
  output logic [8:0] charge_current_select,
  output logic charge_current_halve,
  output logic [1:0] charge_current_offset,
  output logic termination_voltage_drop,
  output logic factory_ship_enable,
  output logic [3:0] junction_regulation_setpoint,
  output logic current_foldback,
  output logic [6:0] input_current_limit,
  output logic [2:0] reverse_buck_current_limit,
  output logic [2:0] zero_cross_threshold,
  output logic [4:0] bypass_voltage_threshold,
  output logic [2:0] slope_comp_level,
  output logic slope_comp_halve,
  output logic [2:0] min_system_voltage,
  output logic force_step_down_phase,
  output logic force_step_up_phase,
  output logic input_loop_wide_bw,
  output logic output_current_loop_wide_bw,
  output logic output_voltage_loop_wide_bw,
  output logic spread_enable,
  output logic spread_pattern,
  output logic [7:0] channel_convert,
  output logic [1:0] averaging_count,
  output logic averaging_enable,
  output logic conversion_start
);
  typedef struct packed {
    logic [7:0] thermal;
    logic [7:0] ilim;
    logic [7:0] ramp;
    logic [7:0] offs;
    logic [7:0] slope;
    logic [7:0] phase;
    logic [7:0] spread;
    logic [7:0] chen;
    logic [7:0] meas;
    logic [7:0] rdata;
    logic ack;
    logic [2:0] hot_sync;
    logic [2:0] cool_sync;
    logic [2:0] done_sync;
    ccac_meas_e mstate;
    logic [31:0] wait_cnt;
    logic start;
    logic [7:0] channels;
    logic flag;
    logic fold;
    logic halve;
    logic vdrop;
    logic [8:0] ccsel;
  } ccac_top_s;

  ccac_top_s st;
  ccac_top_s next_st;
  logic [6:0] ramped_limit;
  logic [31:0] rate_period;
  logic hot;
  logic cool;
  logic done_rise;

  // ----------------------------------------
  // input current limit soft start
  // ----------------------------------------
  ccac_ramp #(
    .RAMP0_CYC(RAMP0_CYC),
    .RAMP1_CYC(RAMP1_CYC),
    .RAMP2_CYC(RAMP2_CYC),
    .RAMP3_CYC(RAMP3_CYC)
  ) u_ramp (
    .mclk(mclk),
    .srst(srst),
    .target_code(st.ilim[6:0]),
    .interval_sel(st.ramp[CCAC_RAMPSEL_LSB +: 2]),
    .applied_code(ramped_limit)
  );

  always_comb begin
    case (st.meas[CCAC_RATE_LSB +: 2])
      2'd0: rate_period = 32'(RATE0_CYC);
      2'd1: rate_period = 32'(RATE1_CYC);
      2'd2: rate_period = 32'(RATE2_CYC);
      default: rate_period = 32'(RATE3_CYC);
    endcase
  end

  // only the second stage of the hot and cool synchronisers is read; done compares its second and third stages for the rising edge
  assign hot = st.hot_sync[1];
  assign cool = st.cool_sync[1];
  assign done_rise = st.done_sync[1] & ~st.done_sync[2];

  always_comb begin
    next_st = st;
    next_st.hot_sync = {st.hot_sync[1:0], junction_over_setpoint};
    next_st.cool_sync = {st.cool_sync[1:0], thermistor_cool_zone};
    next_st.done_sync = {st.done_sync[1:0], conversion_done};
    next_st.start = 1'b0;
    next_st.ack = reg_wr | reg_rd;

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    if (reg_wr) begin
      if (reg_addr == CCAC_THERMAL_OFS) begin
        next_st.thermal = reg_wdata;
      end else if (reg_addr == CCAC_ILIM_OFS) begin
        next_st.ilim = reg_wdata;
      end else if (reg_addr == CCAC_RAMP_OFS) begin
        next_st.ramp = reg_wdata;
      end else if (reg_addr == CCAC_OFFS_OFS) begin
        next_st.offs = reg_wdata;
      end else if (reg_addr == CCAC_SLOPE_OFS) begin
        next_st.slope = reg_wdata;
      end else if (reg_addr == CCAC_PHASE_OFS) begin
        next_st.phase = reg_wdata;
      end else if (reg_addr == CCAC_SPREAD_OFS) begin
        next_st.spread = reg_wdata;
        next_st.spread[CCAC_SPREAD_RSVD_BIT] = 1'b0;
      end else if (reg_addr == CCAC_CHEN_OFS) begin
        next_st.chen = reg_wdata;
      end else if (reg_addr == CCAC_MEAS_OFS) begin
        next_st.meas = reg_wdata;
      end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    if (reg_rd) begin
      if (reg_addr == CCAC_THERMAL_OFS) begin
        next_st.rdata = st.thermal;
      end else if (reg_addr == CCAC_ILIM_OFS) begin
        next_st.rdata = {st.ilim[CCAC_CCTOP_BIT], ramped_limit};
      end else if (reg_addr == CCAC_RAMP_OFS) begin
        next_st.rdata = st.ramp;
      end else if (reg_addr == CCAC_OFFS_OFS) begin
        next_st.rdata = st.offs;
      end else if (reg_addr == CCAC_SLOPE_OFS) begin
        next_st.rdata = st.slope;
      end else if (reg_addr == CCAC_PHASE_OFS) begin
        next_st.rdata = st.phase;
      end else if (reg_addr == CCAC_SPREAD_OFS) begin
        next_st.rdata = st.spread;
      end else if (reg_addr == CCAC_CHEN_OFS) begin
        next_st.rdata = st.chen;
      end else if (reg_addr == CCAC_MEAS_OFS) begin
        next_st.rdata = st.meas;
      end else begin
        next_st.rdata = 8'h00;
      end
    end

    // ----------------------------------------
    // thermal and zone adjustment
    // ----------------------------------------
    // setpoint codes above 9 clamp to the hottest threshold
    next_st.fold = hot;
    next_st.flag = hot;
    next_st.halve = st.thermal[CCAC_PROFILE_BIT] & cool & st.thermal[CCAC_CCCOOL_BIT];
    next_st.vdrop = st.thermal[CCAC_PROFILE_BIT] & cool & st.thermal[CCAC_CVCOOL_BIT];
    next_st.ccsel = {st.ilim[CCAC_CCTOP_BIT], fast_charge_current_code};

    // ----------------------------------------
    // conversion sequencer
    // ----------------------------------------
    case (st.mstate)
      CCAC_IDLE: begin
        if (st.meas[CCAC_ONESHOT_BIT] || st.meas[CCAC_CONT_BIT]) begin
          next_st.start = 1'b1;
          next_st.channels = st.chen;
          next_st.mstate = CCAC_CONVERT;
        end
      end
      CCAC_CONVERT: begin
        if (done_rise) begin
          // a one-shot is finished once its pass is done; a host write of one
          // in the same cycle is kept so the request is not lost
          if (!(reg_wr && reg_addr == CCAC_MEAS_OFS && reg_wdata[CCAC_ONESHOT_BIT])) begin
            next_st.meas[CCAC_ONESHOT_BIT] = 1'b0;
          end
          next_st.wait_cnt = 32'h0000_0000;
          next_st.mstate = CCAC_WAIT;
        end
      end
      CCAC_WAIT: begin
        if (st.meas[CCAC_ONESHOT_BIT]) begin
          next_st.mstate = CCAC_IDLE;
        end else if (!st.meas[CCAC_CONT_BIT]) begin
          next_st.mstate = CCAC_IDLE;
        end else if (st.wait_cnt + 32'h0000_0001 >= rate_period) begin
          next_st.mstate = CCAC_IDLE;
        end else begin
          next_st.wait_cnt = st.wait_cnt + 32'h0000_0001;
        end
      end
      default: begin
        next_st.mstate = CCAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st <= '0;
      st.thermal <= CCAC_THERMAL_RST;
      st.ilim <= CCAC_ILIM_RST;
      st.ramp <= CCAC_RAMP_RST;
      st.offs <= CCAC_OFFS_RST;
      st.slope <= CCAC_SLOPE_RST;
      st.phase <= CCAC_PHASE_RST;
      st.spread <= CCAC_SPREAD_RST;
      st.chen <= CCAC_CHEN_RST;
      st.meas <= CCAC_MEAS_RST;
      st.mstate <= CCAC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = st.rdata;
  assign reg_ack = st.ack;
  assign thermal_regulation_flag = st.flag;
  assign current_foldback = st.fold;
  assign charge_current_select = st.ccsel;
  assign charge_current_halve = st.halve;
  assign termination_voltage_drop = st.vdrop;
  assign charge_current_offset = st.offs[7:6];
  assign factory_ship_enable = st.thermal[CCAC_SHIP_BIT];
  assign junction_regulation_setpoint = (st.thermal[6:3] > CCAC_SETPT_MAX) ?
    CCAC_SETPT_MAX : st.thermal[6:3];
  assign input_current_limit = ramped_limit;
  assign reverse_buck_current_limit = st.ramp[5:3];
  assign zero_cross_threshold = st.ramp[2:0];
  assign bypass_voltage_threshold = st.offs[5:1];
  assign slope_comp_level = st.slope[7:5];
  assign slope_comp_halve = st.offs[0];
  assign min_system_voltage = st.slope[2:0];
  assign force_step_down_phase = st.phase[4];
  assign force_step_up_phase = st.phase[3];
  assign input_loop_wide_bw = st.phase[2];
  assign output_current_loop_wide_bw = st.phase[1];
  assign output_voltage_loop_wide_bw = st.phase[0];
  assign spread_enable = st.spread[1];
  assign spread_pattern = st.spread[3];
  assign channel_convert = st.channels;
  assign averaging_count = st.meas[CCAC_AVGCNT_LSB +: 2];
  assign averaging_enable = st.meas[CCAC_AVGEN_BIT];
  assign conversion_start = st.start;
endmodule : ccac_top

// File: include/ccac_pkg.sv
// ccac_pkg: register map, field positions, reset values and timing counts
// for the charger configuration and measurement control register bank.
// assumes a byte-wide register port with 8-bit addresses, clocked by mclk.
package ccac_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] CCAC_THERMAL_OFS = 8'h1d;
  localparam logic [7:0] CCAC_ILIM_OFS = 8'h1e;
  localparam logic [7:0] CCAC_RAMP_OFS = 8'h1f;
  localparam logic [7:0] CCAC_OFFS_OFS = 8'h20;
  localparam logic [7:0] CCAC_SLOPE_OFS = 8'h21;
  localparam logic [7:0] CCAC_PHASE_OFS = 8'h22;
  localparam logic [7:0] CCAC_SPREAD_OFS = 8'h23;
  localparam logic [7:0] CCAC_CHEN_OFS = 8'h30;
  localparam logic [7:0] CCAC_MEAS_OFS = 8'h31;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] CCAC_THERMAL_RST = 8'h32;
  localparam logic [7:0] CCAC_ILIM_RST = 8'h15;
  localparam logic [7:0] CCAC_RAMP_RST = 8'h9e;
  localparam logic [7:0] CCAC_OFFS_RST = 8'h47;
  localparam logic [7:0] CCAC_SLOPE_RST = 8'h52;
  localparam logic [7:0] CCAC_PHASE_RST = 8'h00;
  localparam logic [7:0] CCAC_SPREAD_RST = 8'h09;
  localparam logic [7:0] CCAC_CHEN_RST = 8'h00;
  localparam logic [7:0] CCAC_MEAS_RST = 8'h00;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CCAC_PROFILE_BIT = 7;
  localparam int CCAC_SETPT_LSB = 3;
  localparam int CCAC_CVCOOL_BIT = 2;
  localparam int CCAC_CCCOOL_BIT = 1;
  localparam int CCAC_SHIP_BIT = 0;
  localparam int CCAC_CCTOP_BIT = 7;
  localparam int CCAC_RAMPSEL_LSB = 6;
  localparam int CCAC_SPREAD_RSVD_BIT = 2;
  localparam int CCAC_ONESHOT_BIT = 0;
  localparam int CCAC_CONT_BIT = 1;
  localparam int CCAC_AVGEN_BIT = 2;
  localparam int CCAC_AVGCNT_LSB = 4;
  localparam int CCAC_RATE_LSB = 6;
  // ----------------------------------------
  // analog decodes
  // ----------------------------------------
  localparam int CCAC_SETPT_BASE_C = 85;
  localparam int CCAC_SETPT_STEP_C = 5;
  localparam logic [3:0] CCAC_SETPT_MAX = 4'h9;
  localparam int CCAC_ILIM_MIN_MA = 50;
  localparam int CCAC_ILIM_STEP_MA = 25;
  localparam logic [6:0] CCAC_ILIM_FLAT_TOP = 7'h03;
  localparam int CCAC_COOL_DROP_MV = 180;
  localparam int CCAC_ZX_BASE_MA = -1200;
  localparam int CCAC_ZX_STEP_MA = 225;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CCAC_CLK_MHZ = 100;
  localparam int CCAC_RAMP0_US = 8;
  localparam int CCAC_RAMP1_US = 256;
  localparam int CCAC_RAMP2_US = 1024;
  localparam int CCAC_RAMP3_US = 4096;
  localparam int CCAC_RAMP0_CYC = CCAC_RAMP0_US * CCAC_CLK_MHZ;
  localparam int CCAC_RAMP1_CYC = CCAC_RAMP1_US * CCAC_CLK_MHZ;
  localparam int CCAC_RAMP2_CYC = CCAC_RAMP2_US * CCAC_CLK_MHZ;
  localparam int CCAC_RAMP3_CYC = CCAC_RAMP3_US * CCAC_CLK_MHZ;
  localparam int CCAC_RATE0_HZ = 1000;
  localparam int CCAC_RATE1_HZ = 100;
  localparam int CCAC_RATE2_HZ = 10;
  localparam int CCAC_RATE3_HZ = 1;
  localparam int CCAC_RATE0_CYC = CCAC_CLK_MHZ * 1000000 / CCAC_RATE0_HZ;
  localparam int CCAC_RATE1_CYC = CCAC_CLK_MHZ * 1000000 / CCAC_RATE1_HZ;
  localparam int CCAC_RATE2_CYC = CCAC_CLK_MHZ * 1000000 / CCAC_RATE2_HZ;
  localparam int CCAC_RATE3_CYC = CCAC_CLK_MHZ * 1000000 / CCAC_RATE3_HZ;

  typedef enum logic [1:0] {
    CCAC_IDLE,
    CCAC_CONVERT,
    CCAC_WAIT
  } ccac_meas_e;
endpackage : ccac_pkg

// File: core/ccac_ramp.sv
// ccac_ramp: soft-start stepper for the input current limit code.
// assumes target code from the register bank, same clock, no pin inputs.
`timescale 1ns/1ns
module ccac_ramp
  import ccac_pkg::*;
#(
  parameter int RAMP0_CYC = CCAC_RAMP0_CYC,
  parameter int RAMP1_CYC = CCAC_RAMP1_CYC,
  parameter int RAMP2_CYC = CCAC_RAMP2_CYC,
  parameter int RAMP3_CYC = CCAC_RAMP3_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [6:0] target_code,
  input wire logic [1:0] interval_sel,
  output logic [6:0] applied_code
);
  typedef struct packed {
    logic [6:0] code;
    logic [31:0] tick;
  } ccac_ramp_s;

  ccac_ramp_s st;
  ccac_ramp_s next_st;
  logic [31:0] period;

  always_comb begin
    case (interval_sel)
      2'd0: period = 32'(RAMP0_CYC);
      2'd1: period = 32'(RAMP1_CYC);
      2'd2: period = 32'(RAMP2_CYC);
      default: period = 32'(RAMP3_CYC);
    endcase
  end

  // ----------------------------------------
  // stepping
  // ----------------------------------------
  // decreases apply at once; only rises are ramped to limit inrush
  always_comb begin
    next_st = st;
    if (target_code <= st.code) begin
      next_st.code = target_code;
      next_st.tick = 32'h0000_0000;
    end else if (st.tick + 32'h0000_0001 >= period) begin
      next_st.code = st.code + 7'h01;
      next_st.tick = 32'h0000_0000;
    end else begin
      next_st.tick = st.tick + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st <= '{code: CCAC_ILIM_RST[6:0], tick: 32'h0000_0000};
    end else begin
      st <= next_st;
    end
  end

  assign applied_code = st.code;
endmodule : ccac_ramp

// File: dv/ccac_monitor.sv
// ccac_monitor: port-level checks for the charger register bank.
// assumes one mclk domain, srst synchronous, attached by the bind below.
`timescale 1ns/1ns
module ccac_monitor
  import ccac_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic junction_over_setpoint,
  input wire logic thermal_regulation_flag,
  input wire logic current_foldback,
  input wire logic factory_ship_enable,
  input wire logic [3:0] junction_regulation_setpoint,
  input wire logic [6:0] input_current_limit,
  input wire logic [2:0] reverse_buck_current_limit,
  input wire logic [2:0] zero_cross_threshold,
  input wire logic [4:0] bypass_voltage_threshold,
  input wire logic [1:0] charge_current_offset,
  input wire logic slope_comp_halve,
  input wire logic [2:0] slope_comp_level,
  input wire logic [2:0] min_system_voltage,
  input wire logic force_step_down_phase,
  input wire logic force_step_up_phase,
  input wire logic input_loop_wide_bw,
  input wire logic output_current_loop_wide_bw,
  input wire logic output_voltage_loop_wide_bw,
  input wire logic spread_enable,
  input wire logic spread_pattern,
  input wire logic [7:0] channel_convert,
  input wire logic conversion_start
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic [7:0] wd_q;
  logic [7:0] chen_sh;
  logic mapped;
  logic [3:0] sp_exp;
  assign mapped = (reg_addr >= 8'h1d && reg_addr <= 8'h23) || reg_addr[7:1] == 7'h18;
  // setpoint codes above the table clamp to the top entry
  assign sp_exp = (wd_q[6:3] > CCAC_SETPT_MAX) ? CCAC_SETPT_MAX : wd_q[6:3];
  always_ff @(posedge mclk) begin
    wd_q <= reg_wdata;
    if (srst) begin
      chen_sh <= 8'h00;
    end else if (reg_wr && reg_addr == CCAC_CHEN_OFS) begin
      chen_sh <= reg_wdata;
    end
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ack_follows: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("no ack after access");
  a_ack_single: assert property (!(reg_wr || reg_rd) |=> !reg_ack)
    else $error("ack without access");
  a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ship_map: assert property (reg_wr && reg_addr == CCAC_THERMAL_OFS |=>
    factory_ship_enable == wd_q[0] && junction_regulation_setpoint == sp_exp)
    else $error("thermal register fields wrong");
  a_zx_map: assert property (reg_wr && reg_addr == CCAC_RAMP_OFS |=>
    reverse_buck_current_limit == wd_q[5:3] && zero_cross_threshold == wd_q[2:0])
    else $error("reverse limit or zero cross wrong");
  a_offs_map: assert property (reg_wr && reg_addr == CCAC_OFFS_OFS |=>
    {charge_current_offset, bypass_voltage_threshold, slope_comp_halve} == wd_q)
    else $error("offset register fields wrong");
  a_slope_map: assert property (reg_wr && reg_addr == CCAC_SLOPE_OFS |=>
    slope_comp_level == wd_q[7:5] && min_system_voltage == wd_q[2:0])
    else $error("slope or minimum system voltage wrong");
  a_phase_map: assert property (reg_wr && reg_addr == CCAC_PHASE_OFS |=>
    {force_step_down_phase, force_step_up_phase, input_loop_wide_bw,
     output_current_loop_wide_bw, output_voltage_loop_wide_bw} == wd_q[4:0])
    else $error("phase or bandwidth bits wrong");
  a_spread_map: assert property (reg_wr && reg_addr == CCAC_SPREAD_OFS |=>
    spread_enable == wd_q[1] && spread_pattern == wd_q[3])
    else $error("spread bits wrong");
  a_setpt_clamp: assert property (junction_regulation_setpoint <= CCAC_SETPT_MAX)
    else $error("setpoint beyond table");
  a_ramp_step: assert property (input_current_limit > $past(input_current_limit) |->
    input_current_limit == $past(input_current_limit) + 7'h01)
    else $error("limit rose by more than one step");
  a_flag_low: assert property (!junction_over_setpoint [*4] |-> !thermal_regulation_flag)
    else $error("regulation flag without hot junction");
  a_flag_pair: assert property (thermal_regulation_flag == current_foldback)
    else $error("foldback and flag disagree");
  a_start_pulse: assert property (conversion_start |=> !conversion_start)
    else $error("start pulse too long");
  a_start_latch: assert property (conversion_start |-> ##[0:1] channel_convert == chen_sh)
    else $error("converted channels differ from enables");
  a_oneshot_start: assert property (reg_wr && reg_addr == CCAC_MEAS_OFS && reg_wdata[0]
    |-> ##[1:3] conversion_start)
    else $error("one-shot did not start");
endmodule : ccac_monitor

bind ccac_top ccac_monitor mon (.mclk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .reg_ack, .junction_over_setpoint, .thermal_regulation_flag,
  .current_foldback, .factory_ship_enable, .junction_regulation_setpoint,
  .input_current_limit, .reverse_buck_current_limit, .zero_cross_threshold,
  .bypass_voltage_threshold, .charge_current_offset, .slope_comp_halve,
  .slope_comp_level, .min_system_voltage,
  .force_step_down_phase, .force_step_up_phase, .input_loop_wide_bw,
  .output_current_loop_wide_bw, .output_voltage_loop_wide_bw, .spread_enable,
  .spread_pattern, .channel_convert, .conversion_start);

// File: dv/tb.sv
// tb: self-checking bench for the charger register bank.
// assumes short ramp and rate parameters; reads are checked off a queue.
`timescale 1ns/1ns
module tb
  import ccac_pkg::*;
;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] fast_charge_current_code = 8'h00;
  logic junction_over_setpoint = 1'b0;
  logic thermistor_cool_zone = 1'b0;
  logic conversion_done = 1'b0;
  logic [7:0] reg_rdata, channel_convert;
  logic [8:0] charge_current_select;
  logic [6:0] input_current_limit, lim;
  logic [1:0] averaging_count;
  logic reg_ack, thermal_regulation_flag, charge_current_halve;
  logic termination_voltage_drop, averaging_enable, conversion_start;
  logic [8:0] nt;
  logic [7:0] wv, chen;
  int failures = 0;
  int cmp_count = 0;
  int starts = 0;
  int n;
  integer seed = 32'h2da5;
  logic [8:0] exp_q[$];
  localparam logic [7:0] OFS [9] = '{8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23,
    8'h30, 8'h31};
  localparam logic [7:0] RSTV [9] = '{8'h32, 8'h15, 8'h9e, 8'h47, 8'h52, 8'h00, 8'h09,
    8'h00, 8'h00};

  // only the intervals the scenarios reach are shortened
  ccac_top #(.RAMP0_CYC(4), .RAMP2_CYC(16), .RATE0_CYC(40), .RATE1_CYC(80)) dut (
    .mclk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack,
    .fast_charge_current_code, .junction_over_setpoint, .thermistor_cool_zone,
    .conversion_done, .thermal_regulation_flag, .charge_current_select,
    .charge_current_halve, .charge_current_offset(), .termination_voltage_drop,
    .factory_ship_enable(), .junction_regulation_setpoint(), .current_foldback(),
    .input_current_limit, .reverse_buck_current_limit(), .zero_cross_threshold(),
    .bypass_voltage_threshold(), .slope_comp_level(), .slope_comp_halve(),
    .min_system_voltage(), .force_step_down_phase(), .force_step_up_phase(),
    .input_loop_wide_bw(), .output_current_loop_wide_bw(),
    .output_voltage_loop_wide_bw(), .spread_enable(), .spread_pattern(),
    .channel_convert, .averaging_count, .averaging_enable, .conversion_start);

  always #5 mclk = ~mclk;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task conclude;
    if (failures == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // one strobe cycle, then an idle cycle so strobes never merge
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [8:0] e);
    @(negedge mclk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    exp_q.push_back(e);
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask : acc

  task wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 9'h000);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00, {1'b1, e});
  endtask : rd

  task cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask : cyc

  // ----------------------------------------
  // output watcher
  // ----------------------------------------
  always @(negedge mclk) begin
    if (conversion_start === 1'b1) starts++;
    if (reg_ack === 1'b1) begin
      if (exp_q.size() == 0) chk("ack", 9'h001, 9'h000);
      else begin
        nt = exp_q.pop_front();
        if (nt[8]) chk("rdata", {1'b0, reg_rdata}, {1'b0, nt[7:0]});
      end
    end
  end

  initial begin
    #200_000;
    failures++;
    conclude();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    cyc(3);
    srst = 1'b0;
    for (int i = 0; i < 9; i++) rd(OFS[i], RSTV[i]);
    for (int i = 0; i < 8; i++) begin
      if (i == 1) continue;
      wv = 8'($random(seed));
      if (i == 0) wv[6] = 1'b0;
      if (i == 4) wv[4:3] = 2'b10;
      if (i == 7) chen = wv;
      wr(OFS[i], wv);
      if (i == 6) wv[2] = 1'b0;
      rd(OFS[i], wv);
    end
    wr(8'h24, 8'h5a);
    rd(8'h24, 8'h00);
    wr(8'h1d, 8'h78);
    thermistor_cool_zone = 1'b1;
    wr(8'h1d, 8'h86);
    cyc(5);
    chk("halve", charge_current_halve, 9'h001);
    chk("drop", termination_voltage_drop, 9'h001);
    wr(8'h1d, 8'h06);
    cyc(2);
    chk("halve", charge_current_halve, 9'h000);
    wr(8'h1d, 8'h82);
    cyc(2);
    chk("drop", termination_voltage_drop, 9'h000);
    thermistor_cool_zone = 1'b0;
    junction_over_setpoint = 1'b1;
    cyc(5);
    chk("halve", charge_current_halve, 9'h000);
    chk("flag", thermal_regulation_flag, 9'h001);
    junction_over_setpoint = 1'b0;
    fast_charge_current_code = 8'($random(seed));
    // fastest ramp so consecutive steps can be timed
    wr(8'h1f, 8'h00);
    wr(8'h1e, 8'h99);
    lim = input_current_limit;
    for (n = 0; n < 50 && input_current_limit === lim; n++) @(negedge mclk);
    lim = input_current_limit;
    for (n = 0; n < 50 && input_current_limit === lim; n++) @(negedge mclk);
    chk("ramp", 9'(n), 9'h004);
    chk("select", charge_current_select, {1'b1, fast_charge_current_code});
    cyc(40);
    rd(8'h1e, 8'h99);
    wr(8'h1e, 8'h10);
    rd(8'h1e, 8'h10);
    starts = 0;
    wr(8'h31, 8'h01);
    cyc(3);
    chk("starts", 9'(starts), 9'h001);
    chk("chan", {1'b0, channel_convert}, {1'b0, chen});
    conversion_done = 1'b1;
    cyc(6);
    rd(8'h31, 8'h00);
    conversion_done = 1'b0;
    starts = 0;
    wr(8'h31, 8'h42);
    repeat (12) begin
      cyc(20);
      conversion_done = ~conversion_done;
    end
    chk("rate", 9'(starts >= 2 && starts <= 4), 9'h001);
    wr(8'h31, 8'h34);
    rd(8'h31, 8'h34);
    chk("avg", {averaging_count, averaging_enable}, 9'h007);
    cyc(5);
    chk("queue", 9'(exp_q.size()), 9'h000);
    conclude();
  end
endmodule : tb
